// ---- bank_decode.sv ----
package static_bank_pkg;
	localparam int NUM_BANKS = 5;
	localparam logic [7:0] OFF_TIMING_BASE = 8'h00;
	localparam logic [7:0] OFF_WINDOW_BASE = 8'h10;
	localparam logic [7:0] OFF_LAST = 8'h1C;
	localparam int POS_HOLD = 12;
	localparam int POS_SETUP = 8;
	localparam int POS_WIDTH = 6;
	localparam int POS_BCM = 3;
	localparam int POS_BLEN = 1;
	localparam int POS_KIND = 0;
	localparam int POS_BASE = 8;
	localparam int POS_MASK = 0;
	localparam logic [2:0] RST_HOLD = 3'h7;
	localparam logic [2:0] RST_SETUP = 3'h7;
	localparam logic [1:0] RST_WIDTH = 2'h0;
	localparam logic [1:0] RST_BLEN = 2'h0;
	localparam logic [7:0] RST_MASK = 8'hFC;
	localparam logic [7:0] BANK0_MASK = 8'hFC;
	localparam logic [7:0] RST_BASE [1:4] = '{8'h18, 8'h14, 8'h0C, 8'h08};
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef struct packed {
		logic [2:0] hold;
		logic [2:0] setup;
		logic [1:0] width;
		logic byte_lane_strobe_mode;
		logic [1:0] blen;
		logic kind;
	} bank_cfg_t;

	typedef struct packed {
		logic [7:0] base;
		logic [7:0] mask;
	} bank_window_t;

	function automatic logic window_hit(input logic [7:0] top, input bank_window_t w);
		return (top & w.mask) == w.base;
	endfunction
endpackage

module bank_decode
	import static_bank_pkg::*;
(
	input wire logic [31:0] i_addr,
	input bank_window_t i_win [1:4],
	output logic [NUM_BANKS-1:0] o_hit
);
	// Lowest bank wins on overlap; overlap itself is a software fault
	always_comb begin
		o_hit = '0;
		if ((i_addr[31:24] & BANK0_MASK) == 8'h00) begin
			o_hit[0] = 1'b1;
		end else if (window_hit(i_addr[31:24], i_win[1])) begin
			o_hit[1] = 1'b1;
		end else if (window_hit(i_addr[31:24], i_win[2])) begin
			o_hit[2] = 1'b1;
		end else if (window_hit(i_addr[31:24], i_win[3])) begin
			o_hit[3] = 1'b1;
		end else if (window_hit(i_addr[31:24], i_win[4])) begin
			o_hit[4] = 1'b1;
		end
	end
endmodule

// ---- static_bank_ctrl.sv ----
// Operation
// - Address held 0-7 cycles after strobe
// - 0-7 setup cycles before strobe asserts
// - Width field selects 8/16/32 bit bank
// - Byte-control bit selects byte-lane strobe mode
// - Byte-control ignored when burst ROM chosen
// - Burst length field gives 4/8/16/32 beats
// - Memory-type bit: normal or burst ROM
// - Reserved control bits read zero, ignore writes
// - Bank active when masked top byte matches
// - Bank zero always decodes at base zero
// - Base bytes reset to 18,14,0C,08
// - Mask bytes reset to FC
// - Decode registers return to defaults on reset
// - Select asserts with address, then strobes
// - Wait input stretches strobe when the setup count is nonzero
module static_bank_ctrl
	import static_bank_pkg::*;
(
	input wire logic I_CLK_SYS,
	input wire logic I_SYS_RST,
	input wire logic I_AWVALID,
	output logic O_AWREADY,
	input wire logic [7:0] I_AWADDR,
	input wire logic I_WVALID,
	output logic O_WREADY,
	input wire logic [31:0] I_WDATA,
	input wire logic [3:0] I_WSTRB,
	output logic O_BVALID,
	input wire logic I_BREADY,
	output logic [1:0] O_BRESP,
	input wire logic I_ARVALID,
	output logic O_ARREADY,
	input wire logic [7:0] I_ARADDR,
	output logic O_RVALID,
	input wire logic I_RREADY,
	output logic [31:0] O_RDATA,
	output logic [1:0] O_RRESP,
	input wire logic I_MEM_REQ,
	input wire logic I_MEM_WRITE,
	input wire logic [31:0] I_MEM_ADDR,
	input wire logic [3:0] I_MEM_BE,
	input wire logic I_WAIT_N,
	output logic O_MEM_BUSY,
	output logic O_MEM_DONE,
	output logic [31:0] O_MEM_ADDR,
	output logic [NUM_BANKS-1:0] O_BANK_SELECT_N,
	output logic O_RD_N,
	output logic [3:0] O_WE_N
);
	typedef enum {ST_IDLE, ST_SETUP, ST_STROBE, ST_HOLD} state_t;

	bank_cfg_t cfg_reg [1:4];
	bank_window_t win_reg [1:4];
	logic aw_full_reg, w_full_reg;
	logic [7:0] aw_addr_reg;
	logic [31:0] w_data_reg;
	logic [3:0] w_strb_reg;
	logic [NUM_BANKS-1:0] hit;
	state_t state_reg;
	logic [2:0] cnt_reg;
	logic [4:0] beats_reg;
	bank_cfg_t act_reg;
	logic write_reg;
	logic [3:0] be_reg;

	function automatic logic mapped(input logic [7:0] a);
		return a[1:0] == 2'h0 && a <= OFF_LAST;
	endfunction

	function automatic logic [31:0] read_word(input logic [7:0] a);
		logic [1:0] idx;
		idx = a[3:2];
		read_word = 32'h0000_0000;
		if (mapped(a) && a < OFF_WINDOW_BASE) begin
			read_word[POS_HOLD +: 3] = cfg_reg[idx + 3'd1].hold;
			read_word[POS_SETUP +: 3] = cfg_reg[idx + 3'd1].setup;
			read_word[POS_WIDTH +: 2] = cfg_reg[idx + 3'd1].width;
			read_word[POS_BCM] = cfg_reg[idx + 3'd1].byte_lane_strobe_mode;
			read_word[POS_BLEN +: 2] = cfg_reg[idx + 3'd1].blen;
			read_word[POS_KIND] = cfg_reg[idx + 3'd1].kind;
		end else if (mapped(a)) begin
			read_word[POS_BASE +: 8] = win_reg[idx + 3'd1].base;
			read_word[POS_MASK +: 8] = win_reg[idx + 3'd1].mask;
		end
	endfunction

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
			input logic [3:0] s);
		for (int b = 0; b < 4; b++) begin
			if (s[b]) begin
				old[8*b +: 8] = d[8*b +: 8];
			end
		end
		return old;
	endfunction

	// Write address and data may arrive in either order; one write in flight
	always_ff @(posedge I_CLK_SYS) begin
		if (I_SYS_RST) begin
			O_AWREADY <= 1'b0;
			O_WREADY <= 1'b0;
			aw_full_reg <= 1'b0;
			w_full_reg <= 1'b0;
			aw_addr_reg <= 8'h00;
			w_data_reg <= 32'h0000_0000;
			w_strb_reg <= 4'h0;
			O_BVALID <= 1'b0;
			O_BRESP <= RESP_OKAY;
		end else begin
			if (I_AWVALID && O_AWREADY) begin
				O_AWREADY <= 1'b0;
				aw_full_reg <= 1'b1;
				aw_addr_reg <= I_AWADDR;
			end else if (!aw_full_reg && !O_BVALID) begin
				O_AWREADY <= 1'b1;
			end
			if (I_WVALID && O_WREADY) begin
				O_WREADY <= 1'b0;
				w_full_reg <= 1'b1;
				w_data_reg <= I_WDATA;
				w_strb_reg <= I_WSTRB;
			end else if (!w_full_reg && !O_BVALID) begin
				O_WREADY <= 1'b1;
			end
			if (aw_full_reg && w_full_reg && !O_BVALID) begin
				aw_full_reg <= 1'b0;
				w_full_reg <= 1'b0;
				O_BVALID <= 1'b1;
				O_BRESP <= mapped(aw_addr_reg) ? RESP_OKAY : RESP_SLVERR;
			end else if (O_BVALID && I_BREADY) begin
				O_BVALID <= 1'b0;
			end
		end
	end

	// Register file; reserved positions are simply not stored
	always_ff @(posedge I_CLK_SYS) begin
		logic [31:0] nw;
		nw = 32'h0000_0000;
		if (I_SYS_RST) begin
			for (int n = 1; n <= 4; n++) begin
				cfg_reg[n] <= '{RST_HOLD, RST_SETUP, RST_WIDTH, 1'b0, RST_BLEN, 1'b0};
				win_reg[n] <= '{RST_BASE[n], RST_MASK};
			end
		end else if (aw_full_reg && w_full_reg && !O_BVALID && mapped(aw_addr_reg)) begin
			nw = merge(read_word(aw_addr_reg), w_data_reg, w_strb_reg);
			if (aw_addr_reg < OFF_WINDOW_BASE) begin
				cfg_reg[aw_addr_reg[3:2] + 3'd1] <= '{nw[POS_HOLD +: 3], nw[POS_SETUP +: 3],
					nw[POS_WIDTH +: 2], nw[POS_BCM], nw[POS_BLEN +: 2], nw[POS_KIND]};
			end else begin
				win_reg[aw_addr_reg[3:2] + 3'd1] <= '{nw[POS_BASE +: 8], nw[POS_MASK +: 8]};
			end
		end
	end

	always_ff @(posedge I_CLK_SYS) begin
		if (I_SYS_RST) begin
			O_ARREADY <= 1'b0;
			O_RVALID <= 1'b0;
			O_RDATA <= 32'h0000_0000;
			O_RRESP <= RESP_OKAY;
		end else if (I_ARVALID && O_ARREADY) begin
			O_ARREADY <= 1'b0;
			O_RVALID <= 1'b1;
			O_RDATA <= read_word(I_ARADDR);
			O_RRESP <= mapped(I_ARADDR) ? RESP_OKAY : RESP_SLVERR;
		end else if (O_RVALID && I_RREADY) begin
			O_RVALID <= 1'b0;
		end else if (!O_RVALID) begin
			O_ARREADY <= 1'b1;
		end
	end

	bank_decode u_decode (
		.i_addr(I_MEM_ADDR),
		.i_win(win_reg),
		.o_hit(hit)
	);

	function automatic bank_cfg_t bank_cfg(input logic [NUM_BANKS-1:0] h);
		bank_cfg = '{RST_HOLD, RST_SETUP, RST_WIDTH, 1'b0, RST_BLEN, 1'b0};
		for (int n = 1; n <= 4; n++) begin
			if (h[n]) begin
				bank_cfg = cfg_reg[n];
			end
		end
	endfunction

	// Bank 0 has no timing register here and uses the reset timing
	logic burst_rd, wait_en, strobe_on, sel_on;
	assign burst_rd = act_reg.kind && !write_reg;
	assign wait_en = act_reg.setup != 3'h0;
	assign strobe_on = !O_RD_N || O_WE_N != 4'hF;
	assign sel_on = O_BANK_SELECT_N != {NUM_BANKS{1'b1}};

	function automatic logic [3:0] lanes(input bank_cfg_t c, input logic wr,
			input logic [3:0] be);
		if (wr || (c.byte_lane_strobe_mode && !c.kind)) begin
			return ~be;
		end
		return 4'hF;
	endfunction

	always_ff @(posedge I_CLK_SYS) begin
		if (I_SYS_RST) begin
			state_reg <= ST_IDLE;
			cnt_reg <= 3'h0;
			beats_reg <= 5'h00;
			act_reg <= '{RST_HOLD, RST_SETUP, RST_WIDTH, 1'b0, RST_BLEN, 1'b0};
			write_reg <= 1'b0;
			be_reg <= 4'h0;
			O_MEM_BUSY <= 1'b0;
			O_MEM_DONE <= 1'b0;
			O_MEM_ADDR <= 32'h0000_0000;
			O_BANK_SELECT_N <= {NUM_BANKS{1'b1}};
			O_RD_N <= 1'b1;
			O_WE_N <= 4'hF;
		end else begin
			O_MEM_DONE <= 1'b0;
			case (state_reg)
				ST_IDLE: begin
					if (I_MEM_REQ && hit == '0) begin
						O_MEM_DONE <= 1'b1;
					end else if (I_MEM_REQ) begin
						act_reg <= bank_cfg(hit);
						write_reg <= I_MEM_WRITE;
						be_reg <= I_MEM_BE;
						O_MEM_BUSY <= 1'b1;
						O_MEM_ADDR <= I_MEM_ADDR;
						O_BANK_SELECT_N <= ~hit;
						beats_reg <= 5'((5'h4 << bank_cfg(hit).blen) - 5'h1);
						if (bank_cfg(hit).setup == 3'h0) begin
							state_reg <= ST_STROBE;
							O_RD_N <= I_MEM_WRITE;
							O_WE_N <= lanes(bank_cfg(hit), I_MEM_WRITE, I_MEM_BE);
						end else begin
							state_reg <= ST_SETUP;
							cnt_reg <= bank_cfg(hit).setup - 3'h1;
						end
					end
				end
				ST_SETUP: begin
					if (cnt_reg == 3'h0) begin
						state_reg <= ST_STROBE;
						O_RD_N <= write_reg;
						O_WE_N <= lanes(act_reg, write_reg, be_reg);
					end else begin
						cnt_reg <= cnt_reg - 3'h1;
					end
				end
				ST_STROBE: begin
					if (wait_en && !I_WAIT_N) begin
						state_reg <= ST_STROBE;
					end else if (burst_rd && beats_reg != 5'h0) begin
						beats_reg <= beats_reg - 5'h1;
						// Width code 3 is reserved; stepping by one byte keeps it harmless
						O_MEM_ADDR <= O_MEM_ADDR + ((act_reg.width == 2'h3) ? 32'h1 :
							(32'h1 << act_reg.width));
					end else begin
						O_RD_N <= 1'b1;
						O_WE_N <= 4'hF;
						if (act_reg.hold == 3'h0) begin
							state_reg <= ST_IDLE;
							O_BANK_SELECT_N <= {NUM_BANKS{1'b1}};
							O_MEM_BUSY <= 1'b0;
							O_MEM_DONE <= 1'b1;
						end else begin
							state_reg <= ST_HOLD;
							cnt_reg <= act_reg.hold - 3'h1;
						end
					end
				end
				ST_HOLD: begin
					if (cnt_reg == 3'h0) begin
						state_reg <= ST_IDLE;
						O_BANK_SELECT_N <= {NUM_BANKS{1'b1}};
						O_MEM_BUSY <= 1'b0;
						O_MEM_DONE <= 1'b1;
					end else begin
						cnt_reg <= cnt_reg - 3'h1;
					end
				end
				default: begin
					state_reg <= ST_IDLE;
				end
			endcase
		end
	end

	logic [3:0] pre_cnt, post_cnt;
	logic [5:0] step_cnt;
	always_ff @(posedge I_CLK_SYS) begin
		if (I_SYS_RST || !sel_on) begin
			pre_cnt <= 4'h0;
		end else if (!strobe_on) begin
			pre_cnt <= pre_cnt + 4'h1;
		end
		if (I_SYS_RST || strobe_on) begin
			post_cnt <= 4'h0;
		end else if (sel_on) begin
			post_cnt <= post_cnt + 4'h1;
		end
		if (I_SYS_RST || !strobe_on) begin
			step_cnt <= 6'h00;
		end else if ($past(strobe_on) && O_MEM_ADDR != $past(O_MEM_ADDR)) begin
			step_cnt <= step_cnt + 6'h01;
		end
	end

	default clocking cb @(posedge I_CLK_SYS); endclocking
	default disable iff (I_SYS_RST);

	sequence idle_req;
		state_reg == ST_IDLE && I_MEM_REQ;
	endsequence
	sequence strobe_start;
		$rose(strobe_on);
	endsequence

	chk_setup_count: assert property (strobe_start |-> pre_cnt == 4'(act_reg.setup))
		else $error("strobe did not follow select by the setup count");
	chk_hold_count: assert property ($fell(sel_on) |-> post_cnt == 4'(act_reg.hold))
		else $error("select released after wrong hold count");
	chk_no_match: assert property (idle_req ##0 hit == '0 |=> !sel_on && O_MEM_DONE)
		else $error("select asserted with no matching bank");
	chk_bank_zero: assert property (idle_req ##0 I_MEM_ADDR[31:26] == 6'h00
		|=> !O_BANK_SELECT_N[0])
		else $error("bank zero not selected at base zero");
	chk_window_match: assert property (idle_req ##0 hit[1]
		|-> (I_MEM_ADDR[31:24] & win_reg[1].mask) == win_reg[1].base)
		else $error("bank one hit without window match");
	chk_reset_defaults: assert property ($fell(I_SYS_RST) |-> win_reg[1].base == 8'h18
		&& win_reg[4].base == 8'h08 && win_reg[2].mask == 8'hFC)
		else $error("decode window not at reset default");
	chk_byte_lanes: assert property (strobe_on && !write_reg
		|-> O_WE_N == ((act_reg.byte_lane_strobe_mode && !act_reg.kind) ? ~be_reg : 4'hF))
		else $error("byte lane strobes wrong during read");
	chk_burst_beats: assert property ($fell(strobe_on) && burst_rd
		|-> step_cnt == 6'((6'h4 << act_reg.blen) - 6'h1))
		else $error("burst beat count wrong");
	chk_wait_stretch: assert property (strobe_on && wait_en && !I_WAIT_N |=> strobe_on)
		else $error("strobe ended while wait asserted");
	chk_reserved_zero: assert property (O_RVALID && O_RDATA[31:16] != 16'h0000 |-> 1'b0)
		else $error("reserved bits read non-zero");
	chk_select_first: assert property (idle_req ##0 hit != '0 |=> sel_on [*2]
		or (sel_on && act_reg.hold == 3'h0))
		else $error("select not asserted with address");
endmodule

// ---- ext_mem_model.sv ----
module ext_mem_model (
	input wire logic i_clk,
	input wire logic i_rd_n,
	input wire logic [3:0] i_we_n,
	input wire logic [3:0] i_stall,
	output logic o_wait_n
);
	timeunit 1ns;
	timeprecision 1ns;
	logic idle;
	logic [3:0] cnt;
	assign idle = i_rd_n & (&i_we_n);
	// A slow part holds wait low for i_stall cycles from each strobe start
	always_ff @(posedge i_clk) begin
		if (idle) begin
			cnt <= i_stall;
		end else if (cnt != 4'h0) begin
			cnt <= cnt - 4'h1;
		end
	end
	assign o_wait_n = idle | (cnt == 4'h0);
endmodule

// ---- static_bank_timing_decode_tb.sv ----
module static_bank_timing_decode_tb
	import static_bank_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	typedef struct packed {
		logic wr;
		logic [7:0] a;
		logic [31:0] d;
		logic [31:0] x;
		logic [1:0] rs;
	} row_t;
	localparam row_t ROWS [11] = '{
		'{1'b0, 8'h00, 32'h0, 32'h7700, 2'h0},
		'{1'b0, 8'h0C, 32'h0, 32'h7700, 2'h0},
		'{1'b0, 8'h10, 32'h0, 32'h18FC, 2'h0},
		'{1'b0, 8'h14, 32'h0, 32'h14FC, 2'h0},
		'{1'b0, 8'h18, 32'h0, 32'h0CFC, 2'h0},
		'{1'b0, 8'h1C, 32'h0, 32'h08FC, 2'h0},
		'{1'b1, 8'h04, 32'hFFFFFFFF, 32'h77CF, 2'h0},
		'{1'b1, 8'h14, 32'hFFFFFFFF, 32'hFFFF, 2'h0},
		'{1'b1, 8'h01, 32'hFFFFFFFF, 32'h0, 2'h2},
		'{1'b1, 8'h20, 32'h0, 32'h0, 2'h2},
		'{1'b0, 8'h00, 32'h0, 32'h7700, 2'h0}
	};
	logic clk, rst, awv, wv, bre, arv, rre, req, mw;
	logic [7:0] awa, ara;
	logic [31:0] wd, ma, rdat, maddr, rd, a0, al;
	logic [3:0] mbe, wen_o, stall, wen;
	logic awr, wrdy, bv, arr, rv, busy, done, rdn, waitn, bz;
	logic [1:0] br, rr, rs;
	logic [NUM_BANKS-1:0] seln, sel;
	int fails, cmp_count, t_sel, t_stb, t_se, t_done, slen;
	static_bank_ctrl dut (.I_CLK_SYS(clk), .I_SYS_RST(rst), .I_AWVALID(awv), .O_AWREADY(awr),
		.I_AWADDR(awa), .I_WVALID(wv), .O_WREADY(wrdy), .I_WDATA(wd), .I_WSTRB(4'hF),
		.O_BVALID(bv), .I_BREADY(bre), .O_BRESP(br), .I_ARVALID(arv), .O_ARREADY(arr),
		.I_ARADDR(ara), .O_RVALID(rv), .I_RREADY(rre), .O_RDATA(rdat), .O_RRESP(rr),
		.I_MEM_REQ(req), .I_MEM_WRITE(mw), .I_MEM_ADDR(ma), .I_MEM_BE(mbe), .I_WAIT_N(waitn),
		.O_MEM_BUSY(busy), .O_MEM_DONE(done), .O_MEM_ADDR(maddr), .O_BANK_SELECT_N(seln),
		.O_RD_N(rdn), .O_WE_N(wen_o));
	ext_mem_model mem_far (.i_clk(clk), .i_rd_n(rdn), .i_we_n(wen_o), .i_stall(stall),
		.o_wait_n(waitn));
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	task automatic finish_test;
		if (fails == 0 && cmp_count > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			fails++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		@(posedge clk);
		awv <= 1'b1;
		wv <= 1'b1;
		awa <= a;
		wd <= d;
		bre <= 1'b1;
		do begin
			@(posedge clk);
			if (awr) awv <= 1'b0;
			if (wrdy) wv <= 1'b0;
		end while (bv !== 1'b1);
		bre <= 1'b0;
		r = br;
	endtask
	task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge clk);
		arv <= 1'b1;
		ara <= a;
		rre <= 1'b1;
		do begin
			@(posedge clk);
			if (arr) arv <= 1'b0;
		end while (rv !== 1'b1);
		rre <= 1'b0;
		d = rdat;
		r = rr;
	endtask
	// Times are counted in negedge samples from the edge that takes the request
	task automatic mem(input logic [31:0] a, input logic w, input logic [3:0] be);
		logic stb;
		@(posedge clk);
		req <= 1'b1;
		ma <= a;
		mw <= w;
		mbe <= be;
		@(posedge clk);
		req <= 1'b0;
		t_done = 0;
		t_sel = 0;
		t_stb = 0;
		slen = 0;
		sel = 5'h1F;
		bz = 1'b0;
		wen = 4'hF;
		do begin
			@(negedge clk);
			t_done++;
			stb = (rdn === 1'b0) || (wen_o !== 4'hF);
			if (seln !== 5'h1F && t_sel == 0) begin
				t_sel = t_done;
				sel = seln;
				a0 = maddr;
				bz = busy;
			end
			if (stb && t_stb == 0) begin
				t_stb = t_done;
				wen = wen_o;
			end
			if (stb) begin
				slen++;
				t_se = t_done;
				al = maddr;
			end
		end while (done !== 1'b1);
	endtask
	task automatic chk_mem(input logic [4:0] s, input int su, input int ho, input int ln,
		input logic [3:0] we);
		chk(sel, s);
		chk(wen, we);
		chk(busy, 1'b0);
		if (s == 5'h1F) begin
			chk(t_done, 1);
		end else begin
			chk(t_sel, 1);
			chk(bz, 1'b1);
			chk(a0, ma);
			chk(t_stb - t_sel, su);
			chk(t_done - t_se - 1, ho);
			chk(slen, ln);
		end
	endtask
	initial begin
		#300000;
		fails++;
		finish_test();
	end
	initial begin
		{awv, wv, bre, arv, rre, req, mw, awa, ara, wd, ma, mbe} = '0;
		stall = 4'h0;
		rst = 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		repeat (2) @(posedge clk);
		foreach (ROWS[i]) begin
			if (ROWS[i].wr) begin
				axw(ROWS[i].a, ROWS[i].d, rs);
				chk(rs, ROWS[i].rs);
			end
			axr(ROWS[i].a, rd, rs);
			chk(rs, ROWS[i].rs);
			if (ROWS[i].rs == RESP_OKAY) chk(rd, ROWS[i].x);
		end
		@(posedge clk);
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		repeat (2) @(posedge clk);
		axr(8'h14, rd, rs);
		chk(rd, 32'h14FC);
		axr(8'h04, rd, rs);
		chk(rd, 32'h7700);
		// Default windows never overlap, so each address reaches one bank only
		mem(32'h00123456, 1'b0, 4'hF);
		chk_mem(5'h1E, 7, 7, 1, 4'hF);
		mem(32'h1B000000, 1'b0, 4'hF);
		chk_mem(5'h1D, 7, 7, 1, 4'hF);
		mem(32'h14000000, 1'b0, 4'hF);
		chk_mem(5'h1B, 7, 7, 1, 4'hF);
		mem(32'h0C000000, 1'b1, 4'hF);
		chk_mem(5'h17, 7, 7, 1, 4'h0);
		mem(32'h08000000, 1'b0, 4'hF);
		chk_mem(5'h0F, 7, 7, 1, 4'hF);
		mem(32'h40000000, 1'b0, 4'hF);
		chk_mem(5'h1F, 0, 0, 0, 4'hF);
		axw(8'h00, 32'h2300, rs);
		mem(32'h18000010, 1'b0, 4'hF);
		chk_mem(5'h1D, 3, 2, 1, 4'hF);
		axw(8'h00, 32'h0000, rs);
		mem(32'h18000010, 1'b0, 4'hF);
		chk_mem(5'h1D, 0, 0, 1, 4'hF);
		axw(8'h00, 32'h1100, rs);
		stall = 4'h3;
		mem(32'h18000000, 1'b0, 4'hF);
		chk(slen > 1, 1);
		stall = 4'h0;
		axw(8'h00, 32'h1108, rs);
		mem(32'h18000000, 1'b0, 4'h5);
		chk_mem(5'h1D, 1, 1, 1, 4'hA);
		mem(32'h18000000, 1'b1, 4'h3);
		chk(wen, 4'hC);
		// Byte-lane bit stays set to show burst mode ignores it; 8-bit bank allows all lengths
		for (int b = 0; b < 4; b++) begin
			axw(8'h00, 32'h1109 | 32'(b << 1), rs);
			mem(32'h18000000, 1'b0, 4'h5);
			chk_mem(5'h1D, 1, 1, 4 << b, 4'hF);
		end
		// Four beats only, which every width permits
		for (int w = 1; w < 3; w++) begin
			axw(8'h00, 32'h1101 | 32'(w << 6), rs);
			mem(32'h18000000, 1'b0, 4'hF);
			chk(al, 32'h18000000 + 32'(3 << w));
		end
		finish_test();
	end
endmodule
